// *** psd_pkg.sv ***
// Constants shared by the slot, DMA and interrupt logic of the serial port
package psd_pkg;

  // Register bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_RX_CFG = 8'h00;
  localparam logic [7:0] OFS_TX_CFG = 8'h04;
  localparam logic [7:0] OFS_DMA_THR = 8'h08;
  localparam logic [7:0] OFS_INT_EN = 8'h0c;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;

  // Reset values
  localparam logic [31:0] RST_RX_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_TX_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_DMA_THR = 32'h1030_3020;
  localparam logic [3:0] RST_INT_EN = 4'h0;
  localparam logic [3:0] RST_INT_STAT = 4'h0;

  // Channel config: first slot in upper half, second slot in lower half
  localparam int SLOT1_BASE = 16;
  localparam int SLOT2_BASE = 0;
  localparam int FLD_WEX = 15;
  localparam int FLD_EN = 14;
  localparam int FLD_POS = 4;
  localparam int FLD_WID = 0;
  localparam logic [5:0] SLOT_MIN_W = 6'h08;
  localparam logic [5:0] SLOT_MAX_W = 6'h20;

  // DMA threshold fields, 7 bits each
  localparam int THR_TX_PANIC = 24;
  localparam int THR_RX_PANIC = 16;
  localparam int THR_TX_REQ = 8;
  localparam int THR_RX_REQ = 0;
  localparam logic [31:0] DMA_THR_MASK = 32'h7f7f_7f7f;

  // Interrupt bit order, same for enable and status
  localparam int IRQ_RX_ERR = 3;
  localparam int IRQ_TX_ERR = 2;
  localparam int IRQ_RX_READ = 1;
  localparam int IRQ_TX_WRITE = 0;

endpackage : psd_pkg

// *** psd_slot_if.sv ***
// Signals between the frame counter and one slot tracker
`timescale 1ns/1ps
interface psd_slot_if;
  logic [9:0] pos;
  logic [3:0] wid;
  logic wex;
  logic en;
  logic tick;
  logic [9:0] cnt;
  logic [5:0] len;
  logic start;
  logic act;
  logic last;
  modport chan (input pos, wid, wex, en, tick, cnt,
                output len, start, act, last);
  modport user (output pos, wid, wex, en, tick, cnt,
                input len, start, act, last);
endinterface : psd_slot_if

// *** psd_slot_chan.sv ***
// Tracks one channel slot: start at its position, count its width
`timescale 1ns/1ps
module psd_slot_chan
  import psd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Frame side
  psd_slot_if.chan s
);

  logic busy_q;
  logic busy_d;
  logic [5:0] left_q;
  logic [5:0] left_d;
  wire [5:0] raw_len = {1'b0, s.wex, s.wid} + SLOT_MIN_W;

  // Widths above the supported maximum are clamped
  assign s.len = (raw_len > SLOT_MAX_W) ? SLOT_MAX_W : raw_len;
  assign s.start = s.tick & ~busy_q & s.en & (s.cnt == s.pos);
  assign s.act = s.start | (s.tick & busy_q);
  assign s.last = s.tick & busy_q & (left_q == 6'h01);
  // Counting ignores frame restarts, so a slot may straddle the boundary
  assign busy_d = s.start | (busy_q & ~s.last);
  assign left_d = s.start ? s.len - 6'h01 :
                  (s.tick & busy_q) ? left_q - 6'h01 : left_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      left_q <= 6'h00;
    end else begin
      busy_q <= busy_d;
      left_q <= left_d;
    end
  end

  a_slot_len_load: assert property (@(posedge clk) disable iff (rst)
    s.start |=> busy_q && left_q == $past(s.len) - 6'h01)
    else $error("slot counter not loaded with width");

endmodule : psd_slot_chan

// *** psd_dma_irq.sv ***
// DMA request and panic levels, interrupt status and its output
`timescale 1ns/1ps
module psd_dma_irq
  import psd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // FIFO state
  input wire logic [6:0] rx_level,
  input wire logic [6:0] tx_level,
  input wire logic [6:0] rx_thr,
  input wire logic [6:0] tx_thr,
  input wire logic rx_fifo_err,
  input wire logic tx_fifo_err,
  // Configuration
  input wire logic [31:0] dma_thr,
  input wire logic [3:0] int_en,
  input wire logic [3:0] stat_clr,
  // Results
  output logic tx_dreq,
  output logic tx_panic,
  output logic rx_dreq,
  output logic rx_panic,
  output logic [3:0] int_stat,
  output logic irq
);

  logic [3:0] cause;
  logic [3:0] stat_d;
  wire [6:0] tx_panic_thr = dma_thr[THR_TX_PANIC +: 7];
  wire [6:0] rx_panic_thr = dma_thr[THR_RX_PANIC +: 7];
  wire [6:0] tx_req_thr = dma_thr[THR_TX_REQ +: 7];
  wire [6:0] rx_req_thr = dma_thr[THR_RX_REQ +: 7];

  assign cause[IRQ_RX_ERR] = rx_fifo_err & int_en[IRQ_RX_ERR];
  assign cause[IRQ_TX_ERR] = tx_fifo_err & int_en[IRQ_TX_ERR];
  assign cause[IRQ_RX_READ] = (rx_level >= rx_thr) &
                              int_en[IRQ_RX_READ];
  assign cause[IRQ_TX_WRITE] = (tx_level < tx_thr) &
                               int_en[IRQ_TX_WRITE];
  // A new cause wins over a clear in the same cycle
  assign stat_d = (int_stat & ~stat_clr) | cause;
  assign irq = |int_stat;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_panic <= 1'b0;
      rx_panic <= 1'b0;
      tx_dreq <= 1'b0;
      rx_dreq <= 1'b0;
      int_stat <= RST_INT_STAT;
    end else begin
      tx_panic <= tx_level < tx_panic_thr;
      rx_panic <= rx_level > rx_panic_thr;
      tx_dreq <= tx_level < tx_req_thr;
      rx_dreq <= rx_level > rx_req_thr;
      int_stat <= stat_d;
    end
  end

  a_tx_panic_level: assert property (@(posedge clk) disable iff (rst)
    (tx_level < tx_panic_thr) |=> tx_panic)
    else $error("tx panic missing below level");
  a_rx_panic_level: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> rx_panic == $past(rx_level > rx_panic_thr))
    else $error("rx panic does not follow level");
  a_tx_req_level: assert property (@(posedge clk) disable iff (rst)
    !(tx_level < tx_req_thr) |=> !tx_dreq)
    else $error("tx request raised at or above level");
  a_rx_req_level: assert property (@(posedge clk) disable iff (rst)
    (rx_level > rx_req_thr) |=> rx_dreq)
    else $error("rx request missing above level");
  a_err_status_set: assert property (@(posedge clk) disable iff (rst)
    (rx_fifo_err && int_en[IRQ_RX_ERR]) |=> int_stat[IRQ_RX_ERR]
    ##0 irq)
    else $error("rx error not latched");
  a_status_w1c: assert property (@(posedge clk) disable iff (rst)
    (stat_clr[IRQ_TX_ERR] && !cause[IRQ_TX_ERR])
    |=> !int_stat[IRQ_TX_ERR])
    else $error("tx error status not cleared");
  a_status_sticky: assert property (@(posedge clk) disable iff (rst)
    (int_stat[IRQ_RX_READ] && !stat_clr[IRQ_RX_READ])
    |=> int_stat[IRQ_RX_READ])
    else $error("rx read status lost without clear");
  a_irq_hold: assert property (@(posedge clk) disable iff (rst)
    irq && !(|stat_clr) |=> irq)
    else $error("interrupt dropped before clear");

endmodule : psd_dma_irq

// *** psd_top.sv ***
// Slot placement, FIFO word mapping, DMA and interrupt registers
`timescale 1ns/1ps
module psd_top
  import psd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Serial link pins
  input wire logic pcm_clk,
  input wire logic pcm_fs,
  input wire logic pcm_din,
  output logic pcm_dout,
  output logic pcm_dout_oe_n,
  // Control from the port's control register
  input wire logic receive_enable,
  input wire logic [6:0] receive_fifo_threshold,
  input wire logic [6:0] transmit_fifo_threshold,
  // Receive FIFO
  output logic rx_push,
  output logic [31:0] rx_data,
  input wire logic [6:0] rx_level,
  input wire logic rx_fifo_err,
  // Transmit FIFO, data valid with pop (show-ahead)
  output logic tx_pop,
  input wire logic [31:0] tx_data,
  input wire logic [6:0] tx_level,
  input wire logic tx_fifo_err,
  // DMA and interrupt
  output logic tx_dreq,
  output logic tx_panic,
  output logic rx_dreq,
  output logic rx_panic,
  output logic irq
);

  // Registers
  logic [31:0] rx_cfg_q;
  logic [31:0] tx_cfg_q;
  logic [31:0] dma_thr_q;
  logic [3:0] int_en_q;
  logic [3:0] int_stat;

  wire sel_rx = reg_addr == OFS_RX_CFG;
  wire sel_tx = reg_addr == OFS_TX_CFG;
  wire sel_dma = reg_addr == OFS_DMA_THR;
  wire sel_en = reg_addr == OFS_INT_EN;
  wire sel_stat = reg_addr == OFS_INT_STAT;
  wire [3:0] stat_clr = (reg_wr & sel_stat) ? reg_wdata[3:0] : 4'h0;
  wire [31:0] rd_mux = sel_rx ? rx_cfg_q :
                       sel_tx ? tx_cfg_q :
                       sel_dma ? dma_thr_q :
                       sel_en ? {28'h0000000, int_en_q} :
                       sel_stat ? {28'h0000000, int_stat} : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_cfg_q <= RST_RX_CFG;
      tx_cfg_q <= RST_TX_CFG;
      dma_thr_q <= RST_DMA_THR;
      int_en_q <= RST_INT_EN;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (reg_wr && sel_rx) rx_cfg_q <= reg_wdata;
      if (reg_wr && sel_tx) tx_cfg_q <= reg_wdata;
      // Reserved threshold bits are kept at zero
      if (reg_wr && sel_dma) dma_thr_q <= reg_wdata & DMA_THR_MASK;
      if (reg_wr && sel_en) int_en_q <= reg_wdata[3:0];
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Link pin synchronisers: clock, frame sync, data
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic clk_prev_q;
  logic fs_prev_q;
  logic [9:0] cnt_q;
  logic rx_run_q;

  wire bclk_rise = pin_s2_q[0] & ~clk_prev_q;
  wire bclk_fall = ~pin_s2_q[0] & clk_prev_q;
  wire frame_begin = bclk_rise & pin_s2_q[1] & ~fs_prev_q;
  wire [9:0] cnt_now = frame_begin ? 10'h000 : cnt_q + 10'h001;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      clk_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
      cnt_q <= 10'h000;
      rx_run_q <= 1'b0;
    end else begin
      pin_s1_q <= {pcm_din, pcm_fs, pcm_clk};
      pin_s2_q <= pin_s1_q;
      clk_prev_q <= pin_s2_q[0];
      if (bclk_rise) begin
        fs_prev_q <= pin_s2_q[1];
        cnt_q <= cnt_now;
      end
      // Starting or stopping reception only takes effect at a frame start
      if (frame_begin) rx_run_q <= receive_enable;
    end
  end

  // Slot trackers: 0/1 receive first/second, 2/3 transmit first/second
  psd_slot_if sif[4] ();
  logic [3:0] s_start;
  logic [3:0] s_act;
  logic [3:0] s_last;
  logic [31:0] rx_cap [2];
  logic [1:0] rx_done;
  logic [1:0] tx_bit;

  for (genvar gi = 0; gi < 4; gi++) begin : g_slot
    localparam int B = (gi % 2 == 0) ? SLOT1_BASE : SLOT2_BASE;
    wire [31:0] cfg = (gi < 2) ? rx_cfg_q : tx_cfg_q;
    wire run = (gi < 2) ? rx_run_q : 1'b1;
    assign sif[gi].pos = cfg[B+FLD_POS +: 10];
    assign sif[gi].wid = cfg[B+FLD_WID +: 4];
    assign sif[gi].wex = cfg[B+FLD_WEX];
    assign sif[gi].en = cfg[B+FLD_EN] & run;
    assign sif[gi].tick = bclk_rise;
    assign sif[gi].cnt = cnt_now;
    assign s_start[gi] = sif[gi].start;
    assign s_act[gi] = sif[gi].act;
    assign s_last[gi] = sif[gi].last;

    psd_slot_chan u_chan (
      .clk(clk),
      .rst(rst),
      .s(sif[gi])
    );

    if (gi < 2) begin : g_rx
      // Bit is taken on the falling edge after the slot's rising edge
      logic pend_q;
      logic lastp_q;
      logic [31:0] sh_q;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pend_q <= 1'b0;
          lastp_q <= 1'b0;
          sh_q <= 32'h0000_0000;
        end else begin
          if (bclk_rise) begin
            pend_q <= s_act[gi];
            lastp_q <= s_last[gi];
          end else if (bclk_fall) begin
            pend_q <= 1'b0;
          end
          if (bclk_fall && pend_q) sh_q <= {sh_q[30:0], pin_s2_q[2]};
        end
      end
      assign rx_cap[gi] = {sh_q[30:0], pin_s2_q[2]};
      assign rx_done[gi] = bclk_fall & pend_q & lastp_q;
    end else begin : g_tx
      // Word left-aligned so its MSB leaves first
      logic [31:0] sh_q;
      wire [5:0] shamt = SLOT_MAX_W - sif[gi].len;
      wire [31:0] aligned = tx_data << shamt;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sh_q <= 32'h0000_0000;
        end else if (s_start[gi]) begin
          sh_q <= {aligned[30:0], 1'b0};
        end else if (s_act[gi]) begin
          sh_q <= {sh_q[30:0], 1'b0};
        end
      end
      assign tx_bit[gi-2] = s_start[gi] ? aligned[31] : sh_q[31];
    end
  end

  // Slot overlap is not checked; one pop per cycle in which either transmit slot starts
  assign tx_pop = s_start[2] | s_start[3];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_push <= 1'b0;
      rx_data <= 32'h0000_0000;
      pcm_dout <= 1'b0;
      pcm_dout_oe_n <= 1'b1;
    end else begin
      rx_push <= |rx_done;
      if (rx_done[0]) rx_data <= rx_cap[0];
      else if (rx_done[1]) rx_data <= rx_cap[1];
      if (bclk_rise) begin
        pcm_dout <= s_act[2] ? tx_bit[0] : (s_act[3] ? tx_bit[1] : 1'b0);
        pcm_dout_oe_n <= ~(s_act[2] | s_act[3]);
      end
    end
  end

  psd_dma_irq u_dma_irq (
    .clk(clk),
    .rst(rst),
    .rx_level(rx_level),
    .tx_level(tx_level),
    .rx_thr(receive_fifo_threshold),
    .tx_thr(transmit_fifo_threshold),
    .rx_fifo_err(rx_fifo_err),
    .tx_fifo_err(tx_fifo_err),
    .dma_thr(dma_thr_q),
    .int_en(int_en_q),
    .stat_clr(stat_clr),
    .tx_dreq(tx_dreq),
    .tx_panic(tx_panic),
    .rx_dreq(rx_dreq),
    .rx_panic(rx_panic),
    .int_stat(int_stat),
    .irq(irq)
  );

  a_tx_pop_enabled: assert property (@(posedge clk) disable iff (rst)
    tx_pop |-> (s_start[2] && tx_cfg_q[SLOT1_BASE+FLD_EN]) ||
    (s_start[3] && tx_cfg_q[SLOT2_BASE+FLD_EN]))
    else $error("transmit pop for disabled channel");
  a_rx_push_running: assert property (@(posedge clk) disable iff (rst)
    rx_push |-> $past(rx_run_q))
    else $error("receive push while reception stopped");
  a_rx_start_frame: assert property (@(posedge clk) disable iff (rst)
    $rose(rx_run_q) |-> $past(frame_begin))
    else $error("reception started off a frame start");

endmodule : psd_top

// *** psd_link_model.sv ***
// Far-end audio device: bit clock, frame sync and data in both directions
`timescale 1ns/1ps
module psd_link_model
  import psd_pkg::*;
#(
  parameter int FLEN = 32,
  parameter time HALF = 100ns
)
(
  // Link pins
  output logic pcm_clk,
  output logic pcm_fs,
  output logic pcm_din,
  input wire logic pcm_dout,
  input wire logic pcm_dout_oe_n,
  // Bits seen on the transmit pin
  output logic [31:0] tx_cap,
  output logic [7:0] tx_bits
);
  initial begin
    pcm_clk = 1'b0;
    pcm_fs = 1'b0;
    pcm_din = 1'b0;
    tx_cap = '0;
    tx_bits = '0;
  end

  // One frame; clock stands still outside frames
  task automatic frame(input logic [FLEN-1:0] pat);
    for (int i = 0; i <= FLEN; i++) begin
      #(HALF/2);
      // Mid-low sampling, clear of the block's sync latency
      if (i > 0 && pcm_dout_oe_n === 1'b0) begin
        tx_cap = {tx_cap[30:0], pcm_dout};
        tx_bits = tx_bits + 8'h01;
      end
      if (i == FLEN) begin
        break;
      end
      pcm_fs = (i == 0);
      #(HALF/2);
      pcm_clk = 1'b1;
      pcm_din = pat[FLEN-1-i];
      #HALF;
      pcm_clk = 1'b0;
    end
    pcm_fs = 1'b0;
    // Released line must not look like held data
    pcm_din = ~pcm_din;
  endtask : frame
endmodule : psd_link_model

// *** test_pcm_slot_dma_irq_config.sv ***
// Self-checking bench: registers, DMA levels, interrupts, link slots
`timescale 1ns/1ps
module test_pcm_slot_dma_irq_config;
  import psd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic pcm_clk, pcm_fs, pcm_din, pcm_dout, pcm_dout_oe_n;
  logic receive_enable = 1'b0;
  logic [6:0] receive_fifo_threshold = 7'h10;
  logic [6:0] transmit_fifo_threshold = 7'h20;
  logic rx_push, tx_pop, tx_dreq, tx_panic, rx_dreq, rx_panic, irq;
  logic [31:0] rx_data;
  logic [31:0] tx_data = 32'hffff_ffa5;
  logic [6:0] rx_level = 7'h00;
  logic [6:0] tx_level = 7'h7f;
  logic rx_fifo_err = 1'b0;
  logic tx_fifo_err = 1'b0;
  logic [31:0] tx_cap;
  logic [7:0] tx_bits;
  int error_cnt = 0;
  int comparisons = 0;
  int pops = 0;
  logic [31:0] got_q[$];

  always #12.5 clk = ~clk;

  psd_top i_psd_top (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pcm_clk, .pcm_fs, .pcm_din, .pcm_dout, .pcm_dout_oe_n,
    .receive_enable, .receive_fifo_threshold, .transmit_fifo_threshold,
    .rx_push, .rx_data, .rx_level, .rx_fifo_err, .tx_pop, .tx_data,
    .tx_level, .tx_fifo_err, .tx_dreq, .tx_panic, .rx_dreq, .rx_panic, .irq);

  psd_link_model i_psd_link_model (.pcm_clk, .pcm_fs, .pcm_din, .pcm_dout,
    .pcm_dout_oe_n, .tx_cap, .tx_bits);

  always @(posedge clk) begin
    if (rx_push === 1'b1) begin
      got_q.push_back(rx_data);
    end
    if (tx_pop === 1'b1) begin
      pops++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  endtask : rchk

  // One-cycle cause; a receive miss sits one step short of the threshold, a transmit miss on it
  task automatic pulse(input int b, input logic hit);
    @(posedge clk);
    case (b)
      3: rx_fifo_err <= hit;
      2: tx_fifo_err <= hit;
      1: rx_level <= receive_fifo_threshold - {6'h0, !hit};
      default: tx_level <= transmit_fifo_threshold - {6'h0, hit};
    endcase
    @(posedge clk);
    rx_fifo_err <= 1'b0;
    tx_fifo_err <= 1'b0;
    rx_level <= 7'h00;
    tx_level <= 7'h7f;
  endtask : pulse

  function automatic logic [31:0] word(input logic [127:0] s, input int k,
                                       input int len);
    logic [31:0] w;
    w = '0;
    for (int j = 0; j < len; j++) begin
      w = {w[30:0], s[127-k-j]};
    end
    return w;
  endfunction : word

  task automatic results();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    logic [7:0] ofs [6];
    logic [31:0] rv [6];
    logic [31:0] wm [6];
    logic [31:0] thr;
    logic [127:0] s;
    logic [31:0] exp_q[$];
    ofs = '{OFS_RX_CFG, OFS_TX_CFG, OFS_DMA_THR, OFS_INT_EN, OFS_INT_STAT,
            8'h14};
    rv = '{32'h0, 32'h0, 32'h1030_3020, 32'h0, 32'h0, 32'h0};
    wm = '{32'hffff_ffff, 32'hffff_ffff, 32'h7f7f_7f7f, 32'hf, 32'h0, 32'h0};
    void'($urandom(32'hb0081d7f));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rchk(ofs[i], 32'hffff_ffff, rv[i]);
    end
    for (int i = 0; i < 6; i++) begin
      // Reserved bits are always written as zero
      wr(ofs[i], wm[i]);
      rchk(ofs[i], wm[i] | 32'h8080_8080, wm[i]);
      wr(ofs[i], 32'h0);
    end
    $display("test registers done");
    for (int n = 0; n < 24; n++) begin
      thr = $urandom() & 32'h7f7f_7f7f;
      wr(OFS_DMA_THR, thr);
      @(posedge clk);
      rx_level <= (n % 2) ? 7'($urandom()) : thr[22:16];
      tx_level <= (n % 2) ? 7'($urandom()) : thr[30:24];
      repeat (2) @(posedge clk);
      #1;
      chk(tx_panic, tx_level < thr[30:24]);
      chk(rx_panic, rx_level > thr[22:16]);
      chk(tx_dreq, tx_level < thr[14:8]);
      chk(rx_dreq, rx_level > thr[6:0]);
    end
    rx_level <= 7'h00;
    tx_level <= 7'h7f;
    $display("test dma levels done");
    for (int b = 0; b < 4; b++) begin
      pulse(b, 1'b1);
      rchk(OFS_INT_STAT, 32'hf, 32'h0);
      wr(OFS_INT_EN, 32'h1 << b);
      pulse(b, 1'b0);
      rchk(OFS_INT_STAT, 32'hf, 32'h0);
      pulse(b, 1'b1);
      rchk(OFS_INT_STAT, 32'hf, 32'h1 << b);
      chk(irq, 1'b1);
      wr(OFS_INT_STAT, ~(32'h1 << b) & 32'hf);
      rchk(OFS_INT_STAT, 32'hf, 32'h1 << b);
      wr(OFS_INT_STAT, 32'h1 << b);
      rchk(OFS_INT_STAT, 32'hf, 32'h0);
      chk(irq, 1'b0);
      wr(OFS_INT_EN, 32'h0);
    end
    $display("test interrupts done");
    // Settings change only while the link clock stands still
    receive_enable <= 1'b1;
    // Link pins move 5 ns off the clk edges, away from the sampling race
    #5;
    i_psd_link_model.frame($urandom());
    repeat (8) @(posedge clk);
    chk(got_q.size(), 0);
    chk(pops, 0);
    wr(OFS_RX_CFG, 32'h41c0_c040);
    wr(OFS_TX_CFG, 32'h4080_0140);
    #5;
    for (int f = 0; f < 4; f++) begin
      s[127-f*32 -: 32] = $urandom();
      i_psd_link_model.frame(s[127-f*32 -: 32]);
    end
    repeat (8) @(posedge clk);
    for (int f = 0; f < 4; f++) begin
      exp_q.push_back(word(s, f*32+4, 24));
      if (f < 3) begin
        exp_q.push_back(word(s, f*32+28, 8));
      end
    end
    chk(got_q.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
      chk(got_q[i] & (i % 2 ? 32'hff : 32'hff_ffff), exp_q[i]);
    end
    chk(pops, 4);
    chk(tx_bits, 32);
    chk(tx_cap, 32'ha5a5_a5a5);
    $display("test link slots done");
    results();
  end
endmodule : test_pcm_slot_dma_irq_config
